// File: pkg/mcu_bus_params.svh
// Purpose: constants of the host bus front end
// Assumes: included by bare name, definitions only
// Notes: field positions index the decode term vector
`ifndef MCU_BUS_PARAMS_SVH
`define MCU_BUS_PARAMS_SVH

`define BUS_WIDTH 16
`define PORT_PINS 8
`define ADDR_RESET 16'h0000
`define DATA_RESET 16'h0000
`define PORT_RESET 8'h00
`define TERM_CTL0_BIT 16
`define TERM_CTL1_BIT 17
`define TERM_CTL2_BIT 18
`define TERM_WIDTH 19
`define SYNC_WIDTH 48

`endif

// File: pkg/mcu_bus_pkg.sv
// Purpose: mode types of the host bus front end
// Assumes: nothing
// Notes: mode inputs are static configuration levels
package mcu_bus_pkg;

	typedef enum logic [1:0] {
		CTL0_WRITE_N = 2'h0,
		CTL0_RW_DIR = 2'h1,
		CTL0_LOW_BYTE_STORE_N = 2'h2
	} ctl0Mode_t;

	typedef enum logic [1:0] {
		CTL1_READ_N = 2'h0,
		CTL1_PHASE_CLOCK = 2'h1,
		CTL1_DATA_STROBE_N = 2'h2,
		CTL1_LOW_LANE_STROBE_N = 2'h3
	} ctl1Mode_t;

	typedef enum logic [2:0] {
		CTL2_CODE_FETCH_SEL_N = 3'h0,
		CTL2_HIGH_BYTE_ENABLE = 3'h1,
		CTL2_UPPER_LANE_STROBE_N = 3'h2,
		CTL2_BYTE_SIZE_SEL = 3'h3,
		CTL2_LOW_BYTE_STROBE_ALT = 3'h4
	} ctl2Mode_t;

	typedef enum logic [1:0] {
		PD0_LATCH_LEVEL = 2'h0,
		PD0_LATCH_RISE = 2'h1,
		PD0_GPIO = 2'h2,
		PD0_LOGIC_IN = 2'h3
	} pd0Mode_t;

	typedef enum logic [1:0] {
		PD_GPIO = 2'h0,
		PD_LOGIC_IN = 2'h1,
		PD_SPECIAL = 2'h2
	} pdMode_t;

	typedef enum logic [2:0] {
		PIN_GPIO = 3'h0,
		PIN_CELL_OUT = 3'h1,
		PIN_IN_LATCHED = 3'h2,
		PIN_IN_TRANSPARENT = 3'h3,
		PIN_IN_REGISTERED = 3'h4
	} pinMode_t;

endpackage : mcu_bus_pkg

// File: src/pin_sync.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are static for at least two clocks per level
// Notes: only the second stage leaves this module
`timescale 1ns/10ps
`include "mcu_bus_params.svh"

module pin_sync
	import mcu_bus_pkg::*;
#(
	parameter int WIDTH = `SYNC_WIDTH
)
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// levels
	input wire logic [WIDTH-1:0] pinLevel,
	output logic [WIDTH-1:0] syncLevel
);

	typedef struct packed
	{
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} syncState_t;

	syncState_t state;
	syncState_t next_state;

	if (WIDTH < 1)
	begin : g_check
		$error("pin_sync: WIDTH must be at least one");
	end

	always_comb
	begin
		next_state.stage1 = pinLevel;
		next_state.stage2 = state.stage1;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			state <= '0;
		else
			state <= next_state;
	end

	assign syncLevel = state.stage2;

endmodule : pin_sync

// File: src/port_pin_mux.sv
// Purpose: per-pin function select of one general port
// Assumes: pin levels arrive already synchronised
// Notes: latched inputs follow the address latch gate
`timescale 1ns/10ps
`include "mcu_bus_params.svh"

module port_pin_mux
	import mcu_bus_pkg::*;
#(
	parameter int PINS = `PORT_PINS
)
(
	// clock and reset
	input wire logic clock,
	input wire logic clear,
	// configuration
	input wire pinMode_t [PINS-1:0] pinMode,
	// pin
	input wire logic [PINS-1:0] pinIn,
	output logic [PINS-1:0] pinOut,
	output logic [PINS-1:0] pinOe,
	// host general i/o and logic side
	input wire logic [PINS-1:0] gpioOut,
	input wire logic [PINS-1:0] gpioDir,
	input wire logic [PINS-1:0] cellOut,
	input wire logic latchGate,
	input wire logic logicTick,
	output logic [PINS-1:0] gpioIn,
	output logic [PINS-1:0] logicIn
);

	typedef struct packed
	{
		logic [PINS-1:0] latched;
		logic [PINS-1:0] registered;
		logic [PINS-1:0] drive;
		logic [PINS-1:0] level;
	} portState_t;

	portState_t state;
	portState_t next_state;

	if (PINS < 1)
	begin : g_check
		$error("port_pin_mux: PINS must be at least one");
	end

	always_comb
	begin
		next_state = state;
		next_state.level = pinIn;
		for (int i = 0; i < PINS; i++)
		begin
			if (latchGate)
				next_state.latched[i] = pinIn[i];
			if (logicTick)
				next_state.registered[i] = pinIn[i];
			case (pinMode[i])
				PIN_GPIO:
				begin
					next_state.drive[i] = gpioOut[i];
				end
				PIN_CELL_OUT:
				begin
					next_state.drive[i] = cellOut[i];
				end
				default:
				begin
					next_state.drive[i] = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (clear)
			state <= '0;
		else
			state <= next_state;
	end

	genvar g;
	for (g = 0; g < PINS; g++)
	begin : g_pin
		assign pinOut[g] = state.drive[g];
		// host outputs fall back to inputs while reset clears the ports
		assign pinOe[g] = (pinMode[g] == PIN_CELL_OUT) ||
			((pinMode[g] == PIN_GPIO) && gpioDir[g] && !clear);
		assign gpioIn[g] = state.level[g];
		assign logicIn[g] = (pinMode[g] == PIN_IN_LATCHED) ?
			state.latched[g] :
			(pinMode[g] == PIN_IN_REGISTERED) ?
			state.registered[g] : state.level[g];
	end

endmodule : port_pin_mux

// File: src/mcu_bus_front_end.sv
// Purpose: host bus front end: address latch, strobes, data drive
// Assumes: host holds address lines three clocks past the strobe
// Notes: every pin level passes pin_sync before use
`timescale 1ns/10ps
`include "mcu_bus_params.svh"

module mcu_bus_front_end
	import mcu_bus_pkg::*;
#(
	parameter int BUS_BITS = `BUS_WIDTH
)
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	input wire logic resetPinN,
	// configuration
	input wire ctl0Mode_t ctl0Mode,
	input wire ctl1Mode_t ctl1Mode,
	input wire ctl2Mode_t ctl2Mode,
	input wire pd0Mode_t pd0Mode,
	input wire pdMode_t pd1Mode,
	input wire pdMode_t pd2Mode,
	input wire pdMode_t pd3Mode,
	input wire pinMode_t [7:0] portAMode,
	input wire pinMode_t [7:0] portBMode,
	input wire pinMode_t [7:0] portCMode,
	// address/data pins
	input wire logic [15:0] adIn,
	output logic [15:0] adOut,
	output logic [15:0] adOe,
	// control pins
	input wire logic control_in_0,
	input wire logic control_in_1,
	input wire logic control_in_2,
	// port pins
	input wire logic [23:0] portIn,
	output logic [23:0] portOut,
	output logic [23:0] portOe,
	input wire logic [3:0] pdIn,
	output logic [3:0] pdOut,
	output logic [3:0] pdOe,
	// host general i/o of the ports
	input wire logic [27:0] gpioOut,
	input wire logic [27:0] gpioDir,
	output logic [27:0] gpioIn,
	// decode and logic side
	input wire logic blockSelect,
	input wire logic [15:0] readData,
	input wire logic [7:0] port_a_macrocell_out,
	input wire logic [7:0] port_b_macrocell_out,
	input wire logic [7:0] ext_chip_select_out,
	output logic [15:0] latchedAddr,
	output logic [`TERM_WIDTH-1:0] decodeTerms,
	output logic [23:0] portLogicIn,
	output logic [3:0] pdLogicIn,
	output logic readActive,
	output logic writeActive,
	output logic lowLaneActive,
	output logic highLaneActive,
	output logic lowByteStore,
	output logic highByteStore,
	output logic memEnable,
	output logic logicTick,
	output logic flashAbort,
	output logic clearActive
);

	if (BUS_BITS != 16)
	begin : g_check
		$error("mcu_bus_front_end: only a 16-bit bus is served");
	end

	typedef struct packed
	{
		logic [15:0] addr;
		logic [15:0] data;
		logic strobePrev;
		logic clockPrev;
		logic tick;
		logic abort;
	} frontState_t;

	frontState_t state;
	frontState_t next_state;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [`SYNC_WIDTH-1:0] syncLevel;
	logic [15:0] adSync;
	logic c0;
	logic c1;
	logic c2;
	logic [3:0] pdSync;
	logic resetPinSync;
	logic [23:0] portSync;

	pin_sync #(.WIDTH(`SYNC_WIDTH)) u_sync (
		.clock(clock),
		.reset(reset),
		.pinLevel({portIn, resetPinN, pdIn, control_in_2,
			control_in_1, control_in_0, adIn}),
		.syncLevel(syncLevel)
	);

	assign adSync = syncLevel[15:0];
	assign c0 = syncLevel[16];
	assign c1 = syncLevel[17];
	assign c2 = syncLevel[18];
	assign pdSync = syncLevel[22:19];
	assign resetPinSync = syncLevel[23];
	assign portSync = syncLevel[47:24];

	// the synchroniser comes out of reset low, so the pin reads as
	// asserted until a high level has passed both stages
	assign clearActive = reset || !resetPinSync;

	////////////////////////////////////////////////////////////////////
	// strobe decode

	logic strobeOn;
	logic strobeRise;
	logic capture;
	logic phaseOn;
	logic fetchRead;
	logic deviceSel;

	assign strobeOn = pdSync[0];
	assign strobeRise = strobeOn && !state.strobePrev;
	assign capture = ((pd0Mode == PD0_LATCH_LEVEL) && strobeOn) ||
		((pd0Mode == PD0_LATCH_RISE) && strobeRise);

	// phase clock counts as active high, the other strobes low
	assign phaseOn = (ctl1Mode == CTL1_PHASE_CLOCK) ? c1 : !c1;
	assign fetchRead = (ctl2Mode == CTL2_CODE_FETCH_SEL_N) && !c2;
	assign deviceSel = (pd2Mode != PD_SPECIAL) || !pdSync[2];

	always_comb
	begin
		readActive = 1'b0;
		writeActive = 1'b0;
		lowByteStore = 1'b0;
		case (ctl0Mode)
			CTL0_RW_DIR:
			begin
				readActive = c0 && phaseOn;
				writeActive = !c0 && phaseOn;
			end
			CTL0_LOW_BYTE_STORE_N:
			begin
				lowByteStore = !c0;
				writeActive = !c0;
				readActive = (ctl1Mode == CTL1_READ_N) && !c1;
			end
			default:
			begin
				writeActive = !c0;
				readActive = (ctl1Mode == CTL1_READ_N) && !c1;
			end
		endcase
		if (fetchRead)
			readActive = 1'b1;
		if (!deviceSel || clearActive)
		begin
			readActive = 1'b0;
			writeActive = 1'b0;
			lowByteStore = 1'b0;
		end
	end

	assign highByteStore = deviceSel && !clearActive &&
		(pd3Mode == PD_SPECIAL) && !pdSync[3];

	always_comb
	begin
		lowLaneActive = readActive || writeActive;
		highLaneActive = readActive || writeActive;
		if (ctl1Mode == CTL1_LOW_LANE_STROBE_N)
			lowLaneActive = !c1 && deviceSel;
		case (ctl2Mode)
			CTL2_HIGH_BYTE_ENABLE, CTL2_UPPER_LANE_STROBE_N:
			begin
				highLaneActive = !c2 && deviceSel;
			end
			CTL2_BYTE_SIZE_SEL:
			begin
				// a byte cycle uses the lane picked by address bit zero
				if (c2)
				begin
					lowLaneActive = lowLaneActive && !state.addr[0];
					highLaneActive = highLaneActive && state.addr[0];
				end
			end
			CTL2_LOW_BYTE_STROBE_ALT:
			begin
				lowLaneActive = !c2 && deviceSel;
			end
			default:
			begin
				highLaneActive = highLaneActive;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// state update

	always_comb
	begin
		next_state = state;
		next_state.strobePrev = strobeOn;
		next_state.clockPrev = pdSync[1];
		next_state.data = readData;
		next_state.abort = 1'b0;
		next_state.tick = (pd1Mode == PD_SPECIAL) &&
			pdSync[1] && !state.clockPrev;
		// address stays put between strobes
		if (capture)
			next_state.addr = adSync;
		if (clearActive)
		begin
			next_state.addr = `ADDR_RESET;
			next_state.data = `DATA_RESET;
			next_state.tick = 1'b0;
			next_state.abort = 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state <= '0;
			state.abort <= 1'b1;
		end
		else
			state <= next_state;
	end

	assign latchedAddr = state.addr;
	assign logicTick = state.tick;
	assign flashAbort = state.abort;
	assign memEnable = deviceSel && !clearActive;

	// data drive is a handshake level, the data itself a flop
	assign adOut = state.data;
	assign adOe = {16{readActive && blockSelect}};

	assign decodeTerms = {c2, c1, c0, state.addr};

	////////////////////////////////////////////////////////////////////
	// ports A to C and port D

	logic [23:0] cellOut;
	assign cellOut = {ext_chip_select_out, port_b_macrocell_out,
		port_a_macrocell_out};

	genvar p;
	for (p = 0; p < 3; p++)
	begin : g_port
		pinMode_t [7:0] mode;
		assign mode = (p == 0) ? portAMode :
			(p == 1) ? portBMode : portCMode;
		port_pin_mux #(.PINS(`PORT_PINS)) u_port (
			.clock(clock),
			.clear(clearActive),
			.pinMode(mode),
			.pinIn(portSync[p*8 +: 8]),
			.pinOut(portOut[p*8 +: 8]),
			.pinOe(portOe[p*8 +: 8]),
			.gpioOut(gpioOut[p*8 +: 8]),
			.gpioDir(gpioDir[p*8 +: 8]),
			.cellOut(cellOut[p*8 +: 8]),
			.latchGate(capture),
			.logicTick(state.tick),
			.gpioIn(gpioIn[p*8 +: 8]),
			.logicIn(portLogicIn[p*8 +: 8])
		);
	end

	logic [3:0] pdGpio;
	assign pdGpio = {pd3Mode == PD_GPIO, pd2Mode == PD_GPIO,
		pd1Mode == PD_GPIO, pd0Mode == PD0_GPIO};
	// port d general outputs stay off while reset clears the ports
	assign pdOut = gpioOut[27:24];
	assign pdOe = pdGpio & gpioDir[27:24] & {4{!clearActive}};
	assign gpioIn[27:24] = pdSync;
	assign pdLogicIn = pdSync;

	////////////////////////////////////////////////////////////////////
	// checks

	a_level_capture: assert property (
		@(posedge clock) disable iff (reset)
		(pd0Mode == PD0_LATCH_LEVEL && strobeOn && !clearActive)
		|=> latchedAddr == $past(adSync))
		else $error("address not taken while latch strobe high");

	a_rise_capture: assert property (
		@(posedge clock) disable iff (reset)
		(pd0Mode == PD0_LATCH_RISE && pdSync[0] && !state.strobePrev
		&& !clearActive) |=> latchedAddr == $past(adSync))
		else $error("address not taken on strobe rise");

	a_addr_hold: assert property (
		@(posedge clock) disable iff (reset)
		(!capture && !clearActive) |=> $stable(latchedAddr))
		else $error("latched address moved between strobes");

	a_drive_gate: assert property (
		@(posedge clock) disable iff (reset)
		adOe[0] |-> (readActive && blockSelect && memEnable))
		else $error("data driven without read and selection");

	a_write_strobe: assert property (
		@(posedge clock) disable iff (reset)
		(ctl0Mode == CTL0_WRITE_N && !c0 && memEnable) |-> writeActive)
		else $error("active-low write not seen");

	a_dir_read: assert property (
		@(posedge clock) disable iff (reset)
		(ctl0Mode == CTL0_RW_DIR && ctl1Mode == CTL1_PHASE_CLOCK
		&& memEnable) |-> (readActive == (c0 && c1)))
		else $error("direction read wrong in phase clock mode");

	a_reset_clear: assert property (
		@(posedge clock) disable iff (reset)
		clearActive |=> (latchedAddr == `ADDR_RESET && flashAbort))
		else $error("reset did not clear address or abort flash");

	a_tick_pulse: assert property (
		@(posedge clock) disable iff (reset)
		logicTick |=> !logicTick)
		else $error("logic tick longer than one cycle");

	a_chip_off: assert property (
		@(posedge clock) disable iff (reset)
		(pd2Mode == PD_SPECIAL && pdSync[2]) |-> (!memEnable && !adOe[0]))
		else $error("memories enabled with chip select high");

	a_high_store: assert property (
		@(posedge clock) disable iff (reset)
		(pd3Mode == PD_SPECIAL && !pdSync[3] && memEnable)
		|-> highByteStore)
		else $error("high byte store missed");

	c_read_drive: cover property (@(posedge clock) disable iff (reset)
		adOe[0] ##1 !adOe[0]);
	c_rise_latch: cover property (@(posedge clock) disable iff (reset)
		pd0Mode == PD0_LATCH_RISE && capture);
	c_tick: cover property (@(posedge clock) disable iff (reset)
		logicTick);

endmodule : mcu_bus_front_end

// File: bench/host_bus_model.sv
// Purpose: host side of the multiplexed address/data and strobe bus
// Assumes: the front end samples its pins on the rising clock edge
// Notes: a released bus shows the device word while adOe[0] is set, else the inverse of the last host word
`timescale 1ns/10ps

module host_bus_model
(
	// clock
	input wire logic clock,
	// device drive
	input wire logic [15:0] adOut,
	input wire logic [15:0] adOe,
	// host pins
	output logic [15:0] adIn,
	output logic strobe,
	output logic readN,
	output logic writeN
);
	logic drive;
	logic [15:0] hostAd;

	// no pull on these lines, so a floating bus must not look stable
	assign adIn = drive ? hostAd : (adOe[0] ? adOut : ~hostAd);

	initial
	begin
		drive = 1'b0;
		hostAd = 16'h0000;
		strobe = 1'b0;
		readN = 1'b1;
		writeN = 1'b1;
	end

	// address held three clocks past the strobe, then the bus is freed
	task automatic latchAddr(input logic [15:0] addr);
		@(posedge clock);
		#2;
		drive = 1'b1;
		hostAd = addr;
		strobe = 1'b1;
		repeat (3) @(posedge clock);
		#2;
		strobe = 1'b0;
		repeat (3) @(posedge clock);
		#2;
		drive = 1'b0;
	endtask : latchAddr

	task automatic setPins(input logic rd, input logic wr);
		@(posedge clock);
		#2;
		readN = rd;
		writeN = wr;
	endtask : setPins
endmodule : host_bus_model

// File: bench/mcu_bus_front_end_bench.sv
// Purpose: self-checking bench of the host bus front end
// Assumes: three edges from pin to latched address
// Notes: settle waits of four clocks run one past the pin latency
`timescale 1ns/10ps

module mcu_bus_front_end_bench
	import mcu_bus_pkg::*;
;
	logic clock, reset, resetPinN, control_in_2, blockSelect, strobe;
	logic readN, writeN;
	ctl0Mode_t ctl0Mode;
	ctl1Mode_t ctl1Mode;
	ctl2Mode_t ctl2Mode;
	pd0Mode_t pd0Mode;
	pdMode_t pd1Mode, pd2Mode, pd3Mode;
	pinMode_t [7:0] portAMode, portBMode, portCMode;
	logic [15:0] adIn, adOut, adOe, readData, latchedAddr;
	logic [23:0] portIn, portOut, portOe;
	logic [3:1] pdPins;
	logic [27:0] gpioOut, gpioDir;
	logic [7:0] port_a_macrocell_out, port_b_macrocell_out;
	logic [7:0] ext_chip_select_out;
	logic [18:0] decodeTerms;
	logic readActive, writeActive, memEnable, logicTick, flashAbort;
	logic lowLaneActive, highLaneActive, lowByteStore, highByteStore;
	logic [23:0] portLogicIn;
	logic [3:0] pdLogicIn;
	logic clearActive;
	int fails, checked, cycles, ticks;
	typedef struct {pd0Mode_t mode; logic [15:0] addr, exp;} row_t;
	row_t rows [6] = '{'{PD0_LATCH_RISE, 16'h1234, 16'h1234},
		'{PD0_LATCH_LEVEL, 16'habcd, 16'habcd},
		'{PD0_LATCH_RISE, 16'hffff, 16'hffff},
		'{PD0_GPIO, 16'h5a5a, 16'hffff},
		'{PD0_LOGIC_IN, 16'h0001, 16'hffff},
		'{PD0_LATCH_RISE, 16'h0000, 16'h0000}};

	mcu_bus_front_end u_mcu_bus_front_end (.clock, .reset, .resetPinN,
		.ctl0Mode, .ctl1Mode, .ctl2Mode, .pd0Mode, .pd1Mode, .pd2Mode,
		.pd3Mode, .portAMode, .portBMode, .portCMode, .adIn, .adOut,
		.adOe, .control_in_0(writeN), .control_in_1(readN),
		.control_in_2, .portIn, .portOut, .portOe,
		.pdIn({pdPins, strobe}), .pdOut(), .pdOe(), .gpioOut, .gpioDir,
		.gpioIn(), .blockSelect, .readData, .port_a_macrocell_out,
		.port_b_macrocell_out, .ext_chip_select_out, .latchedAddr,
		.decodeTerms, .portLogicIn, .pdLogicIn, .readActive,
		.writeActive, .lowLaneActive, .highLaneActive,
		.lowByteStore, .highByteStore, .memEnable, .logicTick,
		.flashAbort, .clearActive);

	host_bus_model u_host_bus_model (.clock, .adOut, .adOe, .adIn,
		.strobe, .readN, .writeN);

	task automatic check(input string what, input logic [23:0] seen,
		input logic [23:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic results();
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask : settle

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cycles++;
		ticks += (logicTick === 1'b1);
		if (cycles == 3000)
		begin
			fails++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{reset, resetPinN, control_in_2, blockSelect} = 4'h9;
		ctl0Mode = CTL0_WRITE_N;
		ctl1Mode = CTL1_READ_N;
		ctl2Mode = CTL2_HIGH_BYTE_ENABLE;
		pd0Mode = PD0_LATCH_RISE;
		pd1Mode = PD_GPIO;
		pd2Mode = PD_GPIO;
		pd3Mode = PD_GPIO;
		portAMode = '{default: PIN_GPIO};
		portBMode = '{default: PIN_GPIO};
		portCMode = '{default: PIN_GPIO};
		{readData, portIn, pdPins, gpioOut, gpioDir} = '0;
		{port_a_macrocell_out, port_b_macrocell_out} = 16'h0000;
		ext_chip_select_out = 8'h00;
		settle(5);
		check("abort in reset", flashAbort, 1'b1);
		check("oe in reset", adOe, 16'h0000);
		check("addr in reset", latchedAddr, 16'h0000);
		resetPinN = 1'b1;
		settle(1);
		reset = 1'b0;
		settle(4);
		check("clear after reset", clearActive, 1'b0);
		foreach (rows[i])
		begin
			pd0Mode = rows[i].mode;
			u_host_bus_model.latchAddr(rows[i].addr);
			check("latched", latchedAddr, rows[i].exp);
			check("terms", decodeTerms[15:0], rows[i].exp);
		end
		pd0Mode = PD0_LATCH_RISE;
		// read strobe, selection and chip select
		{blockSelect, readData} = {1'b1, 16'hc3a5};
		u_host_bus_model.setPins(1'b0, 1'b1);
		settle(4);
		check("read", readActive, 1'b1);
		check("oe read", adOe, 16'hffff);
		check("data", adOut, 16'hc3a5);
		blockSelect = 1'b0;
		settle(1);
		check("oe unselected", adOe, 16'h0000);
		blockSelect = 1'b1;
		pd2Mode = PD_SPECIAL;
		pdPins[2] = 1'b1;
		settle(4);
		check("oe csi high", adOe, 16'h0000);
		check("mem csi high", memEnable, 1'b0);
		pdPins[2] = 1'b0;
		settle(4);
		check("oe csi low", adOe, 16'hffff);
		check("mem csi low", memEnable, 1'b1);
		// write strobe and decode terms of the control pins
		u_host_bus_model.setPins(1'b1, 1'b0);
		settle(4);
		check("write", writeActive, 1'b1);
		check("term c0 low", decodeTerms[16], 1'b0);
		u_host_bus_model.setPins(1'b1, 1'b1);
		settle(4);
		check("write off", writeActive, 1'b0);
		check("terms c0 c1", decodeTerms[17:16], 2'h3);
		// direction hosts qualify the cycle with the data strobe
		ctl0Mode = CTL0_RW_DIR;
		ctl1Mode = CTL1_DATA_STROBE_N;
		u_host_bus_model.setPins(1'b0, 1'b0);
		settle(4);
		check("dir write", writeActive, 1'b1);
		check("dir no read", readActive, 1'b0);
		ctl1Mode = CTL1_PHASE_CLOCK;
		u_host_bus_model.setPins(1'b1, 1'b1);
		settle(4);
		check("phase read", readActive, 1'b1);
		check("phase no write", writeActive, 1'b0);
		ctl1Mode = CTL1_READ_N;
		settle(1);
		check("fetch idle", readActive, 1'b0);
		ctl2Mode = CTL2_CODE_FETCH_SEL_N;
		control_in_2 = 1'b0;
		settle(4);
		check("fetch read", readActive, 1'b1);
		check("term c2", decodeTerms[18], 1'b0);
		// byte stores and lane strobes
		ctl0Mode = CTL0_LOW_BYTE_STORE_N;
		ctl2Mode = CTL2_UPPER_LANE_STROBE_N;
		pd3Mode = PD_SPECIAL;
		u_host_bus_model.setPins(1'b1, 1'b0);
		settle(4);
		check("low store", lowByteStore, 1'b1);
		check("high lane", highLaneActive, 1'b1);
		check("high store", highByteStore, 1'b1);
		ctl2Mode = CTL2_BYTE_SIZE_SEL;
		control_in_2 = 1'b1;
		pdPins[3] = 1'b1;
		settle(4);
		check("byte low lane", lowLaneActive, 1'b1);
		check("byte high lane", highLaneActive, 1'b0);
		check("high store off", highByteStore, 1'b0);
		// logic clock pin gives one tick per rise
		pd1Mode = PD_SPECIAL;
		settle(4);
		ticks = 0;
		pdPins[1] = 1'b1;
		settle(8);
		check("ticks", ticks, 24'd1);
		// macrocell drive on port a, host i/o on port b
		portAMode = '{default: PIN_CELL_OUT};
		port_a_macrocell_out = 8'h96;
		{gpioOut[15:8], gpioDir[15:8], port_b_macrocell_out} = 24'h5aff3c;
		settle(4);
		check("cell oe", portOe[7:0], 8'hff);
		check("cell out", portOut[7:0], 8'h96);
		check("gpio oe", portOe[15:8], 8'hff);
		check("gpio out", portOut[15:8], 8'h5a);
		// latched logic inputs move only with an address strobe
		portCMode = '{default: PIN_IN_LATCHED};
		portIn[23:16] = 8'ha5;
		settle(4);
		check("held input", portLogicIn[23:16], 8'h00);
		u_host_bus_model.latchAddr(16'h2468);
		check("latched input", portLogicIn[23:16], 8'ha5);
		check("latched new", latchedAddr, 16'h2468);
		check("pd logic", pdLogicIn, 4'ha);
		// reset pin in mid-run
		resetPinN = 1'b0;
		settle(4);
		check("pin clear", clearActive, 1'b1);
		check("pin abort", flashAbort, 1'b1);
		check("pin addr", latchedAddr, 16'h0000);
		check("pin oe", portOe[15:8], 8'h00);
		check("pin out", portOut[7:0], 8'h00);
		resetPinN = 1'b1;
		settle(4);
		check("pin release", flashAbort, 1'b0);
		results();
	end
endmodule : mcu_bus_front_end_bench
